// ===== src/swd_pkg.sv
// Shared constants for the single-wire debug bit link
package swd_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned BIT_CYC = 16;
  localparam logic [9:0] BIT_LEN = 10'h010;
  localparam logic [9:0] SAMPLE_AT = 10'h00a;
  localparam logic [9:0] SPEEDUP_AT = 10'h007;
  localparam logic [9:0] ZERO_LOW = 10'h00d;
  localparam logic [9:0] TIMEOUT_CYC = 10'h200;
  localparam logic [9:0] DELAY_CYC = 10'h010;
  localparam logic [9:0] HOST_LOW_CYC = 10'h002;
  localparam logic [9:0] SYNC_MIN_LOW = 10'h080;
  localparam logic [9:0] SYNC_HOST_LOW = 10'h100;
  localparam logic [9:0] SYNC_RESP_LEN = 10'h080;
  localparam logic [3:0] ALT_DIV = 4'h3;
  localparam logic [7:0] CMD_HALT = 8'h90;
  localparam logic [7:0] CMD_GO = 8'h08;
  localparam logic [7:0] CMD_STEP = 8'h10;
  localparam logic [7:0] CMD_RD_STAT = 8'he4;
  localparam logic [7:0] CMD_WR_CTRL = 8'hc4;
  localparam logic [7:0] CMD_RD_BKPT = 8'he2;
  localparam logic [7:0] CMD_WR_BKPT = 8'hc2;
  localparam logic [7:0] CTRL_RESET = 8'hc0;
  localparam int unsigned CTRL_ENABLE_BIT = 7;
  localparam int unsigned CTRL_CLKSEL_BIT = 6;
  localparam int unsigned CTRL_BKPT_EN_BIT = 5;
  localparam int unsigned STAT_BGND_BIT = 4;
endpackage : swd_pkg

// ===== src/swd_link_if.sv
// Single-wire debug pin carrier joining pod and target
interface swd_link_if;
  logic host_oe;
  logic host_out;
  logic tgt_oe;
  logic tgt_out;
  logic line;
  // Pseudo open drain: any low drive wins, else a high drive or the pullup
  assign line = (host_oe && !host_out) || (tgt_oe && !tgt_out) ? 1'b0 : 1'b1;
  modport target (input line, output tgt_oe, output tgt_out);
  modport pod (input line, output host_oe, output host_out);
endinterface : swd_link_if

// ===== src/swd_target.sv
// Target end of the single-wire debug bit link
module swd_target (
  input wire logic clock,
  input wire logic rst_b,
  swd_link_if.target link,
  input wire logic por_flag,
  input wire logic cpu_stopped,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_fetch,
  output logic bgnd_mode,
  output logic cpu_wake,
  output logic wdog_disable,
  output logic osc_keep,
  output logic bkpt_hit,
  output logic sync_seen
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01, ST_RX = 6'h02, ST_TX = 6'h04,
    ST_DELAY = 6'h08, ST_SYNC_WAIT = 6'h10, ST_SYNC_RESP = 6'h20
  } swd_tst_t;
  typedef struct packed {
    logic s1, s2, s3;
    logic strap_done;
    logic alt_en;
    logic [3:0] alt_cnt;
    swd_tst_t st;
    logic [9:0] bit_cnt;
    logic [9:0] idle_cnt;
    logic [9:0] low_cnt;
    logic in_bit;
    logic [4:0] nbits;
    logic [15:0] shreg;
    logic [7:0] cmd;
    logic have_cmd;
    logic [7:0] ctrl;
    logic [15:0] bkpt;
    logic oe, dout;
    logic bgnd, wake, wdog, osc, hit, sync;
  } swd_tstate_t;
  swd_tstate_t q, d;
  logic tick, fall, pin;
  always_comb begin
    // Alternate clock is a divided enable; bus clock means every cycle
    tick = q.ctrl[swd_pkg::CTRL_CLKSEL_BIT] || q.alt_en;
    pin = q.s2;
    fall = q.s3 && !q.s2;
  end
  always_comb begin
    d = q;
    d.s1 = link.line;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.wake = 1'b0;
    d.hit = 1'b0;
    d.sync = 1'b0;
    d.alt_en = 1'b0;
    d.alt_cnt = q.alt_cnt + 4'h1;
    if (q.alt_cnt == swd_pkg::ALT_DIV) begin
      d.alt_cnt = 4'h0;
      d.alt_en = 1'b1;
    end
    // Power-on strap caught after release; other resets keep user mode
    if (!q.strap_done) begin
      d.strap_done = 1'b1;
      d.bgnd = por_flag && !pin;
    end
    d.wdog = q.bgnd;
    d.osc = q.ctrl[swd_pkg::CTRL_ENABLE_BIT] && cpu_stopped;
    // Single breakpoint comparator
    if (q.ctrl[swd_pkg::CTRL_BKPT_EN_BIT] && cpu_fetch && cpu_addr == q.bkpt && !q.bgnd) begin
      d.hit = 1'b1;
      d.bgnd = 1'b1;
    end
    if (tick) begin
      // Our own low drive must never look like a host speed probe
      d.low_cnt = (pin || q.oe) ? 10'h000 : (q.low_cnt == 10'h3ff ? q.low_cnt : q.low_cnt + 10'h001);
      if (q.st != ST_IDLE || q.have_cmd) begin
        d.idle_cnt = q.idle_cnt + 10'h001;
      end
      if (q.in_bit) begin
        d.bit_cnt = q.bit_cnt + 10'h001;
      end
    end
    if (fall) begin
      d.idle_cnt = 10'h000;
      d.in_bit = 1'b1;
      d.bit_cnt = 10'h000;
    end
    case (q.st)
      ST_IDLE, ST_RX: begin
        d.oe = 1'b0;
        if (tick && q.in_bit && q.bit_cnt == swd_pkg::SAMPLE_AT) begin
          d.in_bit = 1'b0;
          d.shreg = {q.shreg[14:0], pin};
          d.nbits = q.nbits + 5'h01;
          d.st = ST_RX;
          if (!q.have_cmd && q.nbits == 5'h07) begin
            d.cmd = {q.shreg[6:0], pin};
            d.have_cmd = 1'b1;
            d.nbits = 5'h00;
            case ({q.shreg[6:0], pin})
              swd_pkg::CMD_HALT: begin
                if (q.ctrl[swd_pkg::CTRL_ENABLE_BIT]) begin
                  d.bgnd = 1'b1;
                  d.wake = 1'b1;
                end
                d.st = ST_DELAY;
                d.bit_cnt = 10'h000;
              end
              swd_pkg::CMD_GO, swd_pkg::CMD_STEP: begin
                if (q.bgnd) d.bgnd = 1'b0;
                d.st = ST_DELAY;
                d.bit_cnt = 10'h000;
              end
              swd_pkg::CMD_RD_STAT: begin
                d.shreg = {q.ctrl[7:5], q.bgnd, 4'h0, 8'h00};
                d.nbits = 5'h08;
                d.st = ST_TX;
              end
              swd_pkg::CMD_RD_BKPT: begin
                d.shreg = q.bkpt;
                d.nbits = 5'h10;
                d.st = ST_TX;
              end
              swd_pkg::CMD_WR_CTRL, swd_pkg::CMD_WR_BKPT: d.st = ST_RX;
              default: begin
                d.have_cmd = 1'b0;
                d.st = ST_IDLE;
              end
            endcase
          end else if (q.have_cmd && q.cmd == swd_pkg::CMD_WR_CTRL && q.nbits == 5'h07) begin
            d.ctrl = {q.shreg[6:0], pin};
            d.have_cmd = 1'b0;
            d.nbits = 5'h00;
            d.st = ST_IDLE;
          end else if (q.have_cmd && q.cmd == swd_pkg::CMD_WR_BKPT && q.nbits == 5'h0f) begin
            d.bkpt = {q.shreg[14:0], pin};
            d.have_cmd = 1'b0;
            d.nbits = 5'h00;
            d.st = ST_IDLE;
          end
        end
      end
      ST_TX: begin
        if (fall) begin
          // Zero bits take the line at once so no high glitch follows the host low
          d.oe = !q.shreg[15];
          d.dout = 1'b0;
        end else if (q.in_bit && tick) begin
          if (q.shreg[15]) begin
            d.oe = (q.bit_cnt == swd_pkg::SPEEDUP_AT - 10'h001);
            d.dout = 1'b1;
          end else begin
            // Low twelve cycles from the edge seen by the synchroniser, then one high cycle
            d.oe = (q.bit_cnt <= swd_pkg::ZERO_LOW - 10'h002);
            d.dout = (q.bit_cnt == swd_pkg::ZERO_LOW - 10'h002);
          end
          // Bit closes before the next host edge can reach the synchroniser output
          if (q.bit_cnt == swd_pkg::ZERO_LOW - 10'h001) begin
            d.in_bit = 1'b0;
            d.oe = 1'b0;
            d.shreg = {q.shreg[14:0], 1'b0};
            d.nbits = q.nbits - 5'h01;
            if (q.nbits == 5'h01) begin
              d.have_cmd = 1'b0;
              d.st = ST_IDLE;
            end
          end
        end
      end
      ST_DELAY: begin
        if (tick && q.bit_cnt == swd_pkg::DELAY_CYC - 10'h001) begin
          d.have_cmd = 1'b0;
          d.st = ST_IDLE;
        end else if (tick) begin
          d.bit_cnt = q.bit_cnt + 10'h001;
        end
        d.in_bit = 1'b0;
      end
      ST_SYNC_WAIT: begin
        d.in_bit = 1'b0;
        if (pin && tick) begin
          d.st = ST_SYNC_RESP;
          d.bit_cnt = 10'h000;
          d.oe = 1'b1;
          d.dout = 1'b0;
          d.sync = 1'b1;
        end
      end
      ST_SYNC_RESP: begin
        d.in_bit = 1'b0;
        if (tick) d.bit_cnt = q.bit_cnt + 10'h001;
        d.dout = (q.bit_cnt == swd_pkg::SYNC_RESP_LEN - 10'h001);
        if (tick && q.bit_cnt == swd_pkg::SYNC_RESP_LEN) begin
          d.oe = 1'b0;
          d.st = ST_IDLE;
        end
      end
      default: d.st = ST_IDLE;
    endcase
    // A very long low is a speed probe, never a data bit
    if (q.low_cnt >= swd_pkg::SYNC_MIN_LOW && q.st != ST_SYNC_RESP && q.st != ST_SYNC_WAIT) begin
      d.st = ST_SYNC_WAIT;
      d.have_cmd = 1'b0;
      d.nbits = 5'h00;
      d.oe = 1'b0;
      d.idle_cnt = 10'h000;
    end
    // Abort leaves mode and stored values untouched
    if (q.idle_cnt >= swd_pkg::TIMEOUT_CYC - 10'h001 && q.st != ST_SYNC_WAIT) begin
      d.st = ST_IDLE;
      d.have_cmd = 1'b0;
      d.nbits = 5'h00;
      d.in_bit = 1'b0;
      d.oe = 1'b0;
      d.idle_cnt = 10'h000;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      q <= '0;
      // Synchroniser keeps running through reset so the strap sees a settled pin
      q.s1 <= link.line;
      q.s2 <= q.s1;
      q.s3 <= q.s2;
      q.st <= ST_IDLE;
      q.ctrl <= swd_pkg::CTRL_RESET;
    end else begin
      q <= d;
    end
  end
  assign link.tgt_oe = q.oe;
  assign link.tgt_out = q.dout;
  assign bgnd_mode = q.bgnd;
  assign cpu_wake = q.wake;
  assign wdog_disable = q.wdog;
  assign osc_keep = q.osc;
  assign bkpt_hit = q.hit;
  assign sync_seen = q.sync;
endmodule : swd_target

// ===== src/swd_pod.sv
// Pod end of the single-wire debug bit link
module swd_pod (
  input wire logic clock,
  input wire logic rst_b,
  swd_link_if.pod link,
  input wire logic req_valid,
  input wire logic req_dir,
  input wire logic req_sync,
  input wire logic [4:0] req_nbits,
  input wire logic [15:0] req_data,
  output logic busy,
  output logic done,
  output logic [15:0] rx_data
);
  typedef enum logic [3:0] {
    PS_IDLE = 4'h1, PS_BIT = 4'h2, PS_SYNC = 4'h4, PS_DELAY = 4'h8
  } swd_pst_t;
  typedef struct packed {
    swd_pst_t st;
    logic [9:0] cnt;
    logic [4:0] left;
    logic dir;
    logic [15:0] sh;
    logic oe, dout, busy, done;
  } swd_pstate_t;
  swd_pstate_t q, d;
  always_comb begin
    d = q;
    d.done = 1'b0;
    d.cnt = q.cnt + 10'h001;
    case (q.st)
      PS_IDLE: begin
        d.oe = 1'b0;
        d.cnt = 10'h000;
        if (req_valid) begin
          d.busy = 1'b1;
          d.dir = req_dir;
          d.sh = req_data;
          d.left = req_nbits;
          d.st = req_sync ? PS_SYNC : PS_BIT;
          d.oe = 1'b1;
          d.dout = 1'b0;
        end
      end
      PS_BIT: begin
        if (q.dir) begin
          d.oe = q.cnt < swd_pkg::HOST_LOW_CYC;
          d.dout = 1'b0;
          if (q.cnt == swd_pkg::SAMPLE_AT) d.sh = {q.sh[14:0], link.line};
        end else begin
          d.oe = 1'b1;
          d.dout = (q.cnt >= swd_pkg::HOST_LOW_CYC - 10'h001) && q.sh[15];
          if (q.cnt == swd_pkg::BIT_LEN - 10'h002) d.dout = 1'b1;
        end
        if (q.cnt == swd_pkg::BIT_LEN - 10'h001) begin
          d.cnt = 10'h000;
          if (!q.dir) d.sh = {q.sh[14:0], 1'b0};
          d.left = q.left - 5'h01;
          d.oe = 1'b1;
          d.dout = 1'b0;
          if (q.left == 5'h01) begin
            d.st = PS_DELAY;
            d.oe = 1'b0;
          end
        end
      end
      PS_SYNC: begin
        d.oe = 1'b1;
        d.dout = (q.cnt == swd_pkg::SYNC_HOST_LOW);
        if (q.cnt == swd_pkg::SYNC_HOST_LOW) begin
          d.st = PS_DELAY;
          d.cnt = 10'h000;
        end
      end
      PS_DELAY: begin
        d.oe = 1'b0;
        if (q.cnt == swd_pkg::DELAY_CYC - 10'h001) begin
          d.st = PS_IDLE;
          d.busy = 1'b0;
          d.done = 1'b1;
        end
      end
      default: d.st = PS_IDLE;
    endcase
  end
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      q <= '0;
      q.st <= PS_IDLE;
    end else begin
      q <= d;
    end
  end
  assign link.host_oe = q.oe;
  assign link.host_out = q.dout;
  assign busy = q.busy;
  assign done = q.done;
  assign rx_data = q.sh;
endmodule : swd_pod

// ===== tb/swd_link_monitor.sv
// Wire protocol checker for the single-wire debug link
module swd_link_monitor (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic host_oe,
  input wire logic host_out,
  input wire logic tgt_oe,
  input wire logic tgt_out,
  input wire logic line
);
  logic host_low;
  logic host_low_q;
  logic [9:0] idle_q;
  logic [9:0] gap_q;
  assign host_low = host_oe && !host_out;
  // Saturating counts: host activity is the only time base the target may follow
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      host_low_q <= 1'b0;
      idle_q <= 10'h3ff;
      gap_q <= 10'h3ff;
    end else begin
      host_low_q <= host_low;
      idle_q <= host_low ? 10'h000 : idle_q + {9'h000, idle_q != 10'h3ff};
      gap_q <= (host_low && !host_low_q) ? 10'h000 : gap_q + {9'h000, gap_q != 10'h3ff};
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_no_clash;
    !(host_oe && tgt_oe && (host_out || tgt_out));
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("both ends drive the pin");
  property p_zero_max;
    $rose(tgt_oe && !tgt_out) && gap_q < 10'h010 |-> ##[1:14] !(tgt_oe && !tgt_out);
  endproperty
  a_zero_max: assert property (p_zero_max) else $error("zero bit low drive too long");
  property p_zero_min;
    $rose(tgt_oe && !tgt_out) && gap_q < 10'h010 |-> (tgt_oe && !tgt_out) [*8];
  endproperty
  a_zero_min: assert property (p_zero_min) else $error("zero bit low drive too short");
  property p_pulse;
    tgt_oe && tgt_out |-> ##[1:2] !tgt_oe;
  endproperty
  a_pulse: assert property (p_pulse) else $error("speedup pulse not brief");
  property p_host_first;
    $rose(tgt_oe) |-> idle_q < 10'h040 || gap_q > 10'h07f;
  endproperty
  a_host_first: assert property (p_host_first) else $error("target drove without host edge");
  property p_timeout;
    tgt_oe |-> idle_q < 10'h200;
  endproperty
  a_timeout: assert property (p_timeout) else $error("target drove after idle timeout");
  property p_host_low2;
    $rose(host_low) |=> host_low;
  endproperty
  a_host_low2: assert property (p_host_low2) else $error("host low under two cycles");
  property p_bit_gap;
    $rose(host_low) |-> gap_q >= 10'h00f;
  endproperty
  a_bit_gap: assert property (p_bit_gap) else $error("bit time shorter than sixteen");
  c_zero: cover property ($rose(tgt_oe && !tgt_out));
  c_one: cover property (tgt_oe && tgt_out && gap_q < 10'h010);
  c_sync: cover property (!line && gap_q == 10'h080);
  c_host_hi: cover property (host_oe && host_out);
endmodule : swd_link_monitor

// ===== tb/single_wire_debug_bit_link_tb_top.sv
// Testbench joining pod and target across the link
module single_wire_debug_bit_link_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic dir;
    logic [4:0] nbits;
    logic [15:0] data;
    logic [15:0] exp;
    logic [15:0] mask;
    logic bg;
  } swd_row_t;
  // Step while running must be ignored, so bg stays low on the step row
  swd_row_t rows [0:13] = '{
    '{1'b0, 5'h08, 16'hc400, 16'h0, 16'h0, 1'b0}, '{1'b0, 5'h08, 16'he000, 16'h0, 16'h0, 1'b0},
    '{1'b0, 5'h08, 16'he400, 16'h0, 16'h0, 1'b0}, '{1'b1, 5'h08, 16'h0, 16'h00e0, 16'h00f0, 1'b0},
    '{1'b0, 5'h08, 16'hc200, 16'h0, 16'h0, 1'b0}, '{1'b0, 5'h10, 16'h1234, 16'h0, 16'h0, 1'b0},
    '{1'b0, 5'h08, 16'he200, 16'h0, 16'h0, 1'b0}, '{1'b1, 5'h10, 16'h0, 16'h1234, 16'hffff, 1'b0},
    '{1'b0, 5'h08, 16'h9000, 16'h0, 16'h0, 1'b1}, '{1'b0, 5'h08, 16'he400, 16'h0, 16'h0, 1'b1},
    '{1'b1, 5'h08, 16'h0, 16'h00f0, 16'h00f0, 1'b1}, '{1'b0, 5'h08, 16'h0800, 16'h0, 16'h0, 1'b0},
    '{1'b0, 5'h08, 16'h1000, 16'h0, 16'h0, 1'b0}, '{1'b0, 5'h08, 16'he400, 16'h0, 16'h0, 1'b0}};
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic por_flag = 1'b1;
  logic cpu_stopped = 1'b1;
  logic [15:0] cpu_addr = 16'h0000;
  logic cpu_fetch = 1'b0;
  logic req_valid = 1'b0;
  logic req_dir = 1'b0;
  logic req_sync = 1'b0;
  logic [4:0] req_nbits = 5'h08;
  logic [15:0] req_data = 16'h0000;
  logic bgnd_mode, cpu_wake, wdog_disable, osc_keep, bkpt_hit, sync_seen, busy, done;
  logic [15:0] rx_data;
  logic wake_seen = 1'b0;
  logic hit_seen = 1'b0;
  logic probe_seen = 1'b0;
  int miscompares = 0;
  int comparisons = 0;
  always #25 clock = ~clock;
  always @(posedge clock) begin
    if (cpu_wake === 1'b1) wake_seen = 1'b1;
    if (bkpt_hit === 1'b1) hit_seen = 1'b1;
    if (sync_seen === 1'b1) probe_seen = 1'b1;
  end
  swd_link_if i_swd_link_if ();
  swd_target i_swd_target (.clock(clock), .rst_b(rst_b), .link(i_swd_link_if), .por_flag(por_flag),
    .cpu_stopped(cpu_stopped), .cpu_addr(cpu_addr), .cpu_fetch(cpu_fetch), .bgnd_mode(bgnd_mode),
    .cpu_wake(cpu_wake), .wdog_disable(wdog_disable), .osc_keep(osc_keep), .bkpt_hit(bkpt_hit),
    .sync_seen(sync_seen));
  swd_pod i_swd_pod (.clock(clock), .rst_b(rst_b), .link(i_swd_link_if), .req_valid(req_valid),
    .req_dir(req_dir), .req_sync(req_sync), .req_nbits(req_nbits), .req_data(req_data), .busy(busy),
    .done(done), .rx_data(rx_data));
  swd_link_monitor i_swd_link_monitor (.clock(clock), .rst_b(rst_b), .host_oe(i_swd_link_if.host_oe),
    .host_out(i_swd_link_if.host_out), .tgt_oe(i_swd_link_if.tgt_oe), .tgt_out(i_swd_link_if.tgt_out),
    .line(i_swd_link_if.line));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic xfer(input logic dir, input logic sync, input logic [4:0] n, input logic [15:0] d);
    int k;
    req_dir = dir;
    req_sync = sync;
    req_nbits = n;
    req_data = d;
    req_valid = 1'b1;
    @(negedge clock);
    req_valid = 1'b0;
    for (k = 0; k < 2000 && done !== 1'b1; k++) @(negedge clock);
    check({15'h0000, done}, 16'h0001);
    @(negedge clock);
  endtask : xfer
  task automatic finish_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    #2000000;
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (5) @(negedge clock);
    rst_b = 1'b1;
    @(negedge clock);
    check({15'h0000, bgnd_mode}, 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 14; i++) begin
      xfer(rows[i].dir, 1'b0, rows[i].nbits, rows[i].data);
      if (rows[i].mask != 16'h0000) check(rx_data & rows[i].mask, rows[i].exp);
      check({15'h0000, bgnd_mode}, {15'h0000, rows[i].bg});
      check({15'h0000, wdog_disable}, {15'h0000, rows[i].bg});
      $display("test row %0d done", i);
    end
    check({15'h0000, wake_seen}, 16'h0001);
    check({15'h0000, osc_keep}, 16'h0001);
    cpu_stopped = 1'b0;
    // Leave the status command hanging so only the idle abort can recover the link
    repeat (600) @(negedge clock);
    xfer(1'b0, 1'b0, 5'h08, 16'he400);
    xfer(1'b1, 1'b0, 5'h08, 16'h0000);
    check(rx_data & 16'h00f0, 16'h00e0);
    $display("test timeout done");
    xfer(1'b0, 1'b1, 5'h00, 16'h0000);
    check({15'h0000, probe_seen}, 16'h0001);
    $display("test probe done");
    cpu_addr = 16'h1234;
    cpu_fetch = 1'b1;
    @(negedge clock);
    cpu_fetch = 1'b0;
    repeat (4) @(negedge clock);
    check({15'h0000, hit_seen}, 16'h0001);
    $display("test breakpoint done");
    finish_test();
  end
endmodule : single_wire_debug_bit_link_tb_top
